/* File: design/puc_defs.svh */
// Offsets, field positions, reset values and timing counts of the undercurrent protection block
`ifndef PUC_DEFS_SVH
`define PUC_DEFS_SVH
// ==========================================================================
// Clock and time base
`define PUC_CLK_HZ        20000000
`define PUC_TICK_MS       1
`define PUC_TICK_CYCLES   (`PUC_CLK_HZ / 1000 * `PUC_TICK_MS)
`define PUC_DLY_UNIT_MS   10
// ==========================================================================
// Register byte offsets
`define PUC_OFS_CTRL      8'h00
`define PUC_OFS_STATUS    8'h04
`define PUC_OFS_IRQ_STAT  8'h08
`define PUC_OFS_IRQ_MASK  8'h0C
`define PUC_OFS_PU_DLY    8'h10
`define PUC_OFS_DO_DLY    8'h14
`define PUC_OFS_DO_RATIO  8'h18
`define PUC_OFS_ZERO_LVL  8'h1C
`define PUC_OFS_RECOV     8'h20
`define PUC_OFS_CNT_PU    8'h24
`define PUC_OFS_CNT_TRIP  8'h28
`define PUC_OFS_CNT_PH    8'h2C
`define PUC_OFS_GRP       8'h40
`define PUC_GRP_STRIDE    8'h08
// ==========================================================================
// Field positions
`define PUC_CTRL_EN       0
`define PUC_CTRL_SUPV     1
`define PUC_CTRL_BLK_LO   4
`define PUC_CTRL_GRP_LO   8
`define PUC_GCFG_MODE     16
// ==========================================================================
// Reset values and ranges (current in 1/1000 In, ratio in 1/100)
`define PUC_THR_RST       16'h02EE
`define PUC_THR_MIN       16'h0064
`define PUC_THR_MAX       16'h07D0
`define PUC_TRIP_RST      16'h0096
`define PUC_TRIP_MAX      16'h7530
`define PUC_PU_RST        16'h0014
`define PUC_PU_MIN        16'h000A
`define PUC_PU_MAX        16'h03E8
`define PUC_DO_RST        16'h0014
`define PUC_DO_MAX        16'h1770
`define PUC_RATIO_RST     16'h0078
`define PUC_RATIO_MIN     16'h0065
`define PUC_RATIO_MAX     16'h012C
`define PUC_ZERO_RST      16'h0064
`define PUC_ZERO_MIN      16'h0028
`define PUC_ZERO_MAX      16'h03E8
`define PUC_RECOV_RST     16'h003C
`define PUC_RECOV_MAX     16'h0064
`endif

/* File: design/puc_pkg.sv */
// Types shared by the undercurrent protection block
package puc_pkg;
  // Three measured phase amplitudes, index 0 = phase_a, 1 = phase_b, 2 = phase_c
  typedef struct packed {
    logic [2:0][15:0] amp;
  } puc_meas_t;

  // Protection outputs
  typedef struct packed {
    logic       pickup;
    logic       trip;
    logic [2:0] phase;
  } puc_flags_t;

  // Pickup block source
  typedef enum logic [1:0] {
    BLK_NONE = 2'h0,
    BLK_VAR1 = 2'h1,
    BLK_VAR2 = 2'h2,
    BLK_VAR3 = 2'h3
  } puc_blk_src_t;

  // Protection sequence, one-hot
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_DELAY = 4'b0010,
    S_PICK  = 4'b0100,
    S_DROP  = 4'b1000
  } puc_state_t;
endpackage : puc_pkg

/* File: design/puc_top.sv */
// Phase undercurrent protection with AHB-Lite register slave
//
// Contract
// - any phase below threshold is a fault
// - global enable No silences pickup and trip
// - per-group operate mode, runs only when On
// - threshold per group, 0,1..2,00 In, default 0,75
// - trip delay per group, 0..300 s, default 1,50
// - fault must persist pickup delay, 10..1000 ms
// - pickup held for drop-out delay, default 0,20
// - reset checked against threshold times drop-out ratio
// - selectable block variable suppresses pickup
// - each instance has its own block input
// - supervision enable gates zero-current blocking
// - block when all phases under zero level
// - stay blocked for recovery time after rise
// - total pickup and trip event counters
// - one pickup counter per phase
`timescale 1ns/100ps
`default_nettype none
`include "puc_defs.svh"

module puc_top import puc_pkg::*; #(
  parameter int unsigned NUM_GROUPS  = 4,
  parameter int unsigned TICK_CYCLES = `PUC_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire puc_meas_t   meas,
  input  wire logic [2:0]  blk_var,
  output puc_flags_t       flags,
  output logic             irq
);

  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

  // ==========================================================================
  // Elaboration checks
  if (NUM_GROUPS < 1 || NUM_GROUPS > 4) begin : g_chk_grp
    $error("NUM_GROUPS must be 1 to 4");
  end
  if (TICK_CYCLES < 1) begin : g_chk_tick
    $error("TICK_CYCLES must be at least 1");
  end

  // Clamp a written setting into its legal range
  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < {16'h0000, lo}) begin
      return lo;
    end else if (v > {16'h0000, hi}) begin
      return hi;
    end
    return v[15:0];
  endfunction : clamp16

  // ==========================================================================
  // Block variable synchroniser, the pins are asynchronous
  logic [2:0] blk_s1_q, blk_s2_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blk_s1_q <= 3'h0;
      blk_s2_q <= 3'h0;
    end else begin
      blk_s1_q <= blk_var;
      blk_s2_q <= blk_s1_q;
    end
  end

  // ==========================================================================
  // Millisecond tick prescaler
  logic [PW-1:0] pre_q, pre_d;
  logic          tick_q, tick_d;
  always_comb begin
    tick_d = 1'b0;
    pre_d  = pre_q + PW'(1);
    if (pre_q >= PW'(TICK_CYCLES - 1)) begin
      pre_d  = '0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  // ==========================================================================
  // Register state
  logic                  en_q, en_d, supv_q, supv_d;
  puc_blk_src_t          blk_src_q, blk_src_d;
  logic [1:0]            grp_q, grp_d;
  logic [15:0]           thr_q [NUM_GROUPS];
  logic [15:0]           thr_d [NUM_GROUPS];
  logic [15:0]           tdly_q [NUM_GROUPS];
  logic [15:0]           tdly_d [NUM_GROUPS];
  logic [NUM_GROUPS-1:0] mode_q, mode_d;
  logic [15:0]           pu_dly_q, pu_dly_d, do_dly_q, do_dly_d, ratio_q, ratio_d;
  logic [15:0]           zero_q, zero_d, recov_q, recov_d;
  logic [2:0]            ist_q, ist_d, imask_q, imask_d;
  logic [31:0]           cnt_pu_q, cnt_pu_d, cnt_trip_q, cnt_trip_d;
  logic [2:0][31:0]      cnt_ph_q, cnt_ph_d;
  logic [7:0]            addr_q, addr_d;
  logic                  wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d, irq_q, irq_d;
  logic [31:0]           rdata_q, rdata_d, rd_val;

  // Protection and supervision state
  puc_state_t  st_q, st_d;
  logic [19:0] tmr_q, tmr_d, ttm_q, ttm_d;
  puc_flags_t  fl_q, fl_d;
  logic        sblk_q, sblk_d;
  logic [15:0] rec_q, rec_d;

  // ==========================================================================
  // Comparators on the active group
  logic [15:0] thr_act;
  logic [2:0]  below, above_rst, under_zero;
  logic        blk_act, go;
  assign thr_act = thr_q[grp_q];
  for (genvar i = 0; i < 3; i++) begin : g_cmp
    assign below[i]      = meas.amp[i] < thr_act;
    assign above_rst[i]  = ({16'h0000, meas.amp[i]} * 32'h0000_0064) >=
                           ({16'h0000, thr_act} * {16'h0000, ratio_q});
    assign under_zero[i] = meas.amp[i] < zero_q;
  end

  // Only this instance's own block pins are looked at
  always_comb begin
    case (blk_src_q)
      BLK_VAR1: blk_act = blk_s2_q[0];
      BLK_VAR2: blk_act = blk_s2_q[1];
      BLK_VAR3: blk_act = blk_s2_q[2];
      default:  blk_act = 1'b0;
    endcase
  end
  assign go = en_q && mode_q[grp_q] && !sblk_q && !blk_act;

  // ==========================================================================
  // Current supervision: block while all phases are near zero, then for the recovery time
  always_comb begin
    rec_d  = rec_q;
    sblk_d = sblk_q;
    if (!supv_q) begin
      rec_d  = 16'h0000;
      sblk_d = 1'b0;
    end else if (&under_zero) begin
      rec_d  = 16'h0000;
      sblk_d = 1'b1;
    end else if (sblk_q) begin
      if (rec_q >= recov_q) begin
        sblk_d = 1'b0;
      end else if (tick_q) begin
        rec_d = rec_q + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Pickup, drop-out and trip sequence
  always_comb begin
    st_d  = st_q;
    tmr_d = tmr_q;
    ttm_d = ttm_q;
    fl_d  = fl_q;
    case (st_q)
      S_IDLE: begin
        tmr_d = 20'h00000;
        if (go && |below) begin
          st_d = S_DELAY;
        end
      end
      S_DELAY: begin
        if (!go || !(|below)) begin
          st_d = S_IDLE;
        end else if (tmr_q >= {4'h0, pu_dly_q}) begin
          st_d = S_PICK;
        end else if (tick_q) begin
          tmr_d = tmr_q + 20'h00001;
        end
      end
      S_PICK: begin
        tmr_d = 20'h00000;
        if (!go) begin
          st_d = S_IDLE;
        end else if (&above_rst) begin
          st_d = S_DROP;
        end
      end
      S_DROP: begin
        if (!go) begin
          st_d = S_IDLE;
        end else if (!(&above_rst)) begin
          st_d = S_PICK;
        end else if (tmr_q >= 20'({4'h0, do_dly_q} * `PUC_DLY_UNIT_MS)) begin
          st_d = S_IDLE;
        end else if (tick_q) begin
          tmr_d = tmr_q + 20'h00001;
        end
      end
      default: st_d = S_IDLE;
    endcase
    fl_d.pickup = (st_d == S_PICK) || (st_d == S_DROP);
    if (!fl_d.pickup) begin
      ttm_d      = 20'h00000;
      fl_d.trip  = 1'b0;
      fl_d.phase = 3'h0;
    end else begin
      fl_d.phase = fl_q.phase | below;
      fl_d.trip  = fl_q.pickup && (fl_q.trip || ttm_q >= 20'({4'h0, tdly_q[grp_q]} * `PUC_DLY_UNIT_MS));
      if (tick_q && !fl_q.trip) begin
        ttm_d = ttm_q + 20'h00001;
      end
    end
  end

  // ==========================================================================
  // Read multiplexer over the register map, unmapped reads give zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_q == `PUC_OFS_CTRL) begin
      rd_val[`PUC_CTRL_EN]                   = en_q;
      rd_val[`PUC_CTRL_SUPV]                 = supv_q;
      rd_val[`PUC_CTRL_BLK_LO +: 2]          = blk_src_q;
      rd_val[`PUC_CTRL_GRP_LO +: 2]          = grp_q;
    end else if (addr_q == `PUC_OFS_STATUS) begin
      rd_val[11:0] = {st_q, 1'b0, sblk_q, blk_act, fl_q.phase, fl_q.trip, fl_q.pickup};
    end else if (addr_q == `PUC_OFS_IRQ_STAT) begin
      rd_val[2:0] = ist_q;
    end else if (addr_q == `PUC_OFS_IRQ_MASK) begin
      rd_val[2:0] = imask_q;
    end else if (addr_q == `PUC_OFS_PU_DLY) begin
      rd_val[15:0] = pu_dly_q;
    end else if (addr_q == `PUC_OFS_DO_DLY) begin
      rd_val[15:0] = do_dly_q;
    end else if (addr_q == `PUC_OFS_DO_RATIO) begin
      rd_val[15:0] = ratio_q;
    end else if (addr_q == `PUC_OFS_ZERO_LVL) begin
      rd_val[15:0] = zero_q;
    end else if (addr_q == `PUC_OFS_RECOV) begin
      rd_val[15:0] = recov_q;
    end else if (addr_q == `PUC_OFS_CNT_PU) begin
      rd_val = cnt_pu_q;
    end else if (addr_q == `PUC_OFS_CNT_TRIP) begin
      rd_val = cnt_trip_q;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (addr_q == `PUC_OFS_CNT_PH + 8'(4 * p)) begin
          rd_val = cnt_ph_q[p];
        end
      end
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (addr_q == `PUC_OFS_GRP + 8'(g) * `PUC_GRP_STRIDE) begin
          rd_val = {15'h0000, mode_q[g], thr_q[g]};
        end else if (addr_q == `PUC_OFS_GRP + 8'(g) * `PUC_GRP_STRIDE + 8'h04) begin
          rd_val[15:0] = tdly_q[g];
        end
      end
    end
  end

  // ==========================================================================
  // Bus slave, register writes, event flags and counters
  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    ev  = {sblk_d & ~sblk_q, fl_d.trip & ~fl_q.trip, fl_d.pickup & ~fl_q.pickup};
    clr = 3'h0;
    en_d = en_q; supv_d = supv_q; blk_src_d = blk_src_q; grp_d = grp_q;
    thr_d = thr_q; tdly_d = tdly_q; mode_d = mode_q;
    pu_dly_d = pu_dly_q; do_dly_d = do_dly_q; ratio_d = ratio_q;
    zero_d = zero_q; recov_d = recov_q; imask_d = imask_q;
    cnt_pu_d = cnt_pu_q; cnt_trip_d = cnt_trip_q; cnt_ph_d = cnt_ph_q;
    addr_d = addr_q; rdata_d = rdata_q; rdy_d = rdy_q;
    wr_d = 1'b0; rd_d = 1'b0;
    // Address phase; reads take one wait state so a preceding write is visible
    if (hsel && htrans[1] && hready) begin
      addr_d = haddr[7:0];
      wr_d   = hwrite;
      rd_d   = !hwrite;
      rdy_d  = hwrite;
    end
    if (rd_q) begin
      rdata_d = rd_val;
      rdy_d   = 1'b1;
    end
    // Data phase of a write; settings are forced into their legal ranges
    if (wr_q) begin
      if (addr_q == `PUC_OFS_CTRL) begin
        en_d      = hwdata[`PUC_CTRL_EN];
        supv_d    = hwdata[`PUC_CTRL_SUPV];
        blk_src_d = puc_blk_src_t'(hwdata[`PUC_CTRL_BLK_LO +: 2]);
        grp_d     = (32'(hwdata[`PUC_CTRL_GRP_LO +: 2]) < NUM_GROUPS) ?
                    hwdata[`PUC_CTRL_GRP_LO +: 2] : 2'(NUM_GROUPS - 1);
      end else if (addr_q == `PUC_OFS_IRQ_STAT) begin
        clr = hwdata[2:0];
      end else if (addr_q == `PUC_OFS_IRQ_MASK) begin
        imask_d = hwdata[2:0];
      end else if (addr_q == `PUC_OFS_PU_DLY) begin
        pu_dly_d = clamp16(hwdata, `PUC_PU_MIN, `PUC_PU_MAX);
      end else if (addr_q == `PUC_OFS_DO_DLY) begin
        do_dly_d = clamp16(hwdata, 16'h0000, `PUC_DO_MAX);
      end else if (addr_q == `PUC_OFS_DO_RATIO) begin
        ratio_d = clamp16(hwdata, `PUC_RATIO_MIN, `PUC_RATIO_MAX);
      end else if (addr_q == `PUC_OFS_ZERO_LVL) begin
        zero_d = clamp16(hwdata, `PUC_ZERO_MIN, `PUC_ZERO_MAX);
      end else if (addr_q == `PUC_OFS_RECOV) begin
        recov_d = clamp16(hwdata, 16'h0000, `PUC_RECOV_MAX);
      end else if (addr_q == `PUC_OFS_CNT_PU) begin
        cnt_pu_d = 32'h0000_0000;
      end else if (addr_q == `PUC_OFS_CNT_TRIP) begin
        cnt_trip_d = 32'h0000_0000;
      end else begin
        for (int p = 0; p < 3; p++) begin
          if (addr_q == `PUC_OFS_CNT_PH + 8'(4 * p)) begin
            cnt_ph_d[p] = 32'h0000_0000;
          end
        end
        for (int g = 0; g < NUM_GROUPS; g++) begin
          if (addr_q == `PUC_OFS_GRP + 8'(g) * `PUC_GRP_STRIDE) begin
            thr_d[g]  = clamp16({16'h0000, hwdata[15:0]}, `PUC_THR_MIN, `PUC_THR_MAX);
            mode_d[g] = hwdata[`PUC_GCFG_MODE];
          end else if (addr_q == `PUC_OFS_GRP + 8'(g) * `PUC_GRP_STRIDE + 8'h04) begin
            tdly_d[g] = clamp16(hwdata, 16'h0000, `PUC_TRIP_MAX);
          end
        end
      end
    end
    // Counting wins over a clear in the same cycle
    if (ev[0]) cnt_pu_d = cnt_pu_d + 32'h0000_0001;
    if (ev[1]) cnt_trip_d = cnt_trip_d + 32'h0000_0001;
    for (int p = 0; p < 3; p++) begin
      if (fl_d.phase[p] && !fl_q.phase[p]) begin
        cnt_ph_d[p] = cnt_ph_d[p] + 32'h0000_0001;
      end
    end
    // Sticky flags: a new event beats a write-one-to-clear
    ist_d = (ist_q & ~clr) | ev;
    irq_d = |(ist_q & imask_q);
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0; supv_q <= 1'b0; blk_src_q <= BLK_NONE; grp_q <= 2'h0;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        thr_q[g]  <= `PUC_THR_RST;
        tdly_q[g] <= `PUC_TRIP_RST;
      end
      mode_q   <= '0;
      pu_dly_q <= `PUC_PU_RST;    do_dly_q <= `PUC_DO_RST;
      ratio_q  <= `PUC_RATIO_RST; zero_q   <= `PUC_ZERO_RST;
      recov_q  <= `PUC_RECOV_RST;
      ist_q <= 3'h0; imask_q <= 3'h0; irq_q <= 1'b0;
      cnt_pu_q <= 32'h0000_0000; cnt_trip_q <= 32'h0000_0000; cnt_ph_q <= '0;
      addr_q <= 8'h00; wr_q <= 1'b0; rd_q <= 1'b0; rdy_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      st_q <= S_IDLE; tmr_q <= 20'h00000; ttm_q <= 20'h00000; fl_q <= '0;
      sblk_q <= 1'b0; rec_q <= 16'h0000;
    end else begin
      en_q <= en_d; supv_q <= supv_d; blk_src_q <= blk_src_d; grp_q <= grp_d;
      thr_q <= thr_d; tdly_q <= tdly_d; mode_q <= mode_d;
      pu_dly_q <= pu_dly_d; do_dly_q <= do_dly_d;
      ratio_q  <= ratio_d;  zero_q   <= zero_d;
      recov_q  <= recov_d;
      ist_q <= ist_d; imask_q <= imask_d; irq_q <= irq_d;
      cnt_pu_q <= cnt_pu_d; cnt_trip_q <= cnt_trip_d; cnt_ph_q <= cnt_ph_d;
      addr_q <= addr_d; wr_q <= wr_d; rd_q <= rd_d; rdy_q <= rdy_d;
      rdata_q <= rdata_d;
      st_q <= st_d; tmr_q <= tmr_d; ttm_q <= ttm_d; fl_q <= fl_d;
      sblk_q <= sblk_d; rec_q <= rec_d;
    end
  end

  // Outputs straight from flops; response is always OKAY
  assign hreadyout = rdy_q;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign flags     = fl_q;
  assign irq       = irq_q;

endmodule : puc_top
`default_nettype wire

/* File: testbench/puc_top_sva.sv */
// Port-level assertions for the undercurrent protection block
`timescale 1ns/100ps
`default_nettype none

module puc_chk import puc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = 20000
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire puc_flags_t  flags
);
  // ==========================================================================
  // Helper logic
  logic [15:0] up_q;
  logic [15:0] up_d;

  // Cycles since reset, saturating so it never wraps back into range
  always_comb begin
    up_d = (up_q == 16'hFFFF) ? up_q : up_q + 16'h0001;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q <= 16'h0000;
    end else begin
      up_q <= up_d;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence rd_taken_s; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence wr_taken_s; hsel && htrans[1] && hready && hwrite; endsequence
  sequence rd_wait_s; !hreadyout ##1 hreadyout; endsequence

  rd_wait_a: assert property (rd_taken_s |=> rd_wait_s)
    else $error("read data phase not one wait state");
  wr_zero_a: assert property (wr_taken_s |=> hreadyout)
    else $error("write data phase stalled");
  rdata_hold_a: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data changed outside a read");
  pu_cause_a: assert property ($rose(flags.pickup) |-> flags.phase != 3'h0)
    else $error("pickup without a phase below threshold");
  pu_min_a: assert property ($rose(flags.pickup) |-> up_q >= 10 * TICK_CYCLES)
    else $error("pickup sooner than the shortest pickup delay");
  phase_pick_a: assert property (flags.phase != 3'h0 |-> flags.pickup)
    else $error("phase flag without pickup");
  trip_pick_a: assert property (flags.trip |-> flags.pickup)
    else $error("trip without pickup");
  trip_after_a: assert property ($rose(flags.trip) |-> $past(flags.pickup))
    else $error("trip rose before pickup");
  drop_clear_a: assert property ($fell(flags.pickup) |-> flags.phase == 3'h0 && !flags.trip)
    else $error("phase or trip flags outlived pickup");
  trip_seen_c: cover property ($rose(flags.trip));
endmodule : puc_chk

`default_nettype wire

/* File: testbench/tb_phase_undercurrent_protection.sv */
// Self-checking bench of the undercurrent protection block
`timescale 1ns/100ps
`default_nettype none

module tb_phase_undercurrent_protection import puc_pkg::*;;
  // ==========================================================================
  // Signals and design
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} puc_row_t;
  localparam int unsigned TK = 4; // Short tick keeps delay tests to a few hundred cycles
  logic        clk     = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [2:0]  blk_var = 3'h0;
  logic [31:0] hrdata, rd;
  logic        hready, hreadyout, hresp, irq;
  puc_meas_t   meas;
  puc_flags_t  flags;
  int          err_total = 0;
  int          samples_checked = 0;
  int          n;
  // Out-of-range writes read back the clamped value; then unmapped, status and counter rows
  puc_row_t rows [14] = '{'{8'h10, 32'h5, 32'hA}, '{8'h10, 32'h7D0, 32'h3E8},
    '{8'h14, 32'h1B58, 32'h1770}, '{8'h18, 32'h32, 32'h65}, '{8'h18, 32'h190, 32'h12C},
    '{8'h1C, 32'hA, 32'h28}, '{8'h1C, 32'h7D0, 32'h3E8}, '{8'h20, 32'hC8, 32'h64},
    '{8'h40, 32'h10010, 32'h10064}, '{8'h48, 32'hFFF, 32'h7D0}, '{8'h44, 32'hFFFF, 32'h7530},
    '{8'h3C, 32'h1234, 32'h0}, '{8'h04, 32'hFFFF, 32'h100}, '{8'h24, 32'h5, 32'h0}};
  // Reset values, counters after the first pickup, and the working setup
  puc_row_t rsts [12] = '{'{8'h00, 32'h0, 32'h0}, '{8'h10, 32'h0, 32'h14}, '{8'h14, 32'h0, 32'h14},
    '{8'h18, 32'h0, 32'h78}, '{8'h1C, 32'h0, 32'h64}, '{8'h20, 32'h0, 32'h3C},
    '{8'h40, 32'h0, 32'h2EE}, '{8'h44, 32'h0, 32'h96}, '{8'h48, 32'h0, 32'h2EE},
    '{8'h0C, 32'h0, 32'h0}, '{8'h24, 32'h0, 32'h0}, '{8'h28, 32'h0, 32'h0}};
  puc_row_t cnts [6] = '{'{8'h24, 32'h0, 32'h1}, '{8'h28, 32'h0, 32'h1}, '{8'h2C, 32'h0, 32'h0},
    '{8'h30, 32'h0, 32'h1}, '{8'h34, 32'h0, 32'h0}, '{8'h08, 32'h0, 32'h3}};
  puc_row_t cfg [7] = '{'{8'h10, 32'hA, 32'h0}, '{8'h14, 32'h1, 32'h0}, '{8'h20, 32'h5, 32'h0},
    '{8'h44, 32'h2, 32'h0}, '{8'h40, 32'h102EE, 32'h0}, '{8'h0C, 32'h1, 32'h0}, '{8'h00, 32'h13, 32'h0}};

  assign hready = hreadyout;

  // Free-running 20 MHz clock
  always #25 clk = ~clk;

  puc_top #(.NUM_GROUPS(4), .TICK_CYCLES(TK)) DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .meas(meas), .blk_var(blk_var), .flags(flags), .irq(irq));

  // ==========================================================================
  // Tasks
  task automatic wrap_up;
    $display("Counts: %0d mismatches in %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH at %0t: delay %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  // Samples ready at each edge; a stuck slave ends the run
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        err_total++;
        $display("MISMATCH at %0t: bus wait timed out", $time);
        wrap_up();
      end
      @(posedge clk);
    end
  endtask : wait_ready
  // One single AHB-Lite transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk_val({31'h0, hresp}, 32'h0);
  endtask : ahb
  // Counts edges until pickup (which 0) or trip (which 1) reaches lvl
  task automatic wait_flag(input int which, input logic lvl);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 400) begin
        err_total++;
        $display("MISMATCH at %0t: flag wait timed out", $time);
        wrap_up();
      end
    end while (((which == 0) ? flags.pickup : flags.trip) !== lvl);
  endtask : wait_flag

  // ==========================================================================
  // Main sequence
  initial begin
    meas.amp = {3{16'h03E8}};
    tick(6);
    reset_n <= 1'b1;
    tick(1);
    foreach (rows[i]) begin
      ahb(1'b1, rows[i].a, rows[i].d);
      ahb(1'b0, rows[i].a, 32'h0);
      chk_val(rd, rows[i].e);
    end
    // Second reset in mid-run restores every setting
    reset_n <= 1'b0;
    tick(2);
    chk_val({hreadyout, irq, 25'h0, flags}, 32'h80000000);
    tick(4);
    reset_n <= 1'b1;
    tick(1);
    foreach (rsts[i]) begin
      ahb(1'b0, rsts[i].a, 32'h0);
      chk_val(rd, rsts[i].e);
    end
    foreach (cfg[i]) ahb(1'b1, cfg[i].a, cfg[i].d);
    // A dip shorter than the pickup delay is filtered out
    meas.amp[1] <= 16'h01F4;
    tick(20);
    meas.amp[1] <= 16'h03E8;
    tick(60);
    chk_val({27'h0, flags}, 32'h0);
    meas.amp[1] <= 16'h01F4;
    wait_flag(0, 1'b1);
    chk_rng(n, 40, 48);
    chk_val({27'h0, flags}, 32'h12);
    tick(2);
    chk_val({31'h0, irq}, 32'h1);
    wait_flag(1, 1'b1);
    chk_rng(n, 74, 86);
    // Between threshold and reset level pickup holds; above it, drop-out delay runs
    meas.amp[1] <= 16'h0352;
    tick(80);
    chk_val({27'h0, flags}, 32'h1A);
    meas.amp[1] <= 16'h03E8;
    wait_flag(0, 1'b0);
    chk_rng(n, 38, 50);
    foreach (cnts[i]) begin
      ahb(1'b0, cnts[i].a, 32'h0);
      chk_val(rd, cnts[i].e);
    end
    ahb(1'b1, 8'h08, 32'h7);
    ahb(1'b1, 8'h0C, 32'h0);
    ahb(1'b0, 8'h08, 32'h0);
    chk_val({rd[30:0], irq}, 32'h0);
    // Selected block variable suppresses pickup, the others do not
    blk_var <= 3'h1;
    meas.amp[0] <= 16'h01F4;
    tick(80);
    ahb(1'b0, 8'h04, 32'h0);
    chk_val(rd & 32'hF63, 32'h120);
    blk_var <= 3'h6;
    wait_flag(0, 1'b1);
    chk_rng(n, 40, 54);
    tick(2);
    chk_val({31'h0, irq}, 32'h0);
    blk_var <= 3'h7;
    wait_flag(0, 1'b0);
    chk_rng(n, 1, 8);
    // Zero-current block and its recovery time
    blk_var <= 3'h0;
    meas.amp <= {3{16'h0032}};
    tick(80);
    ahb(1'b0, 8'h04, 32'h0);
    chk_val(rd & 32'hF63, 32'h140);
    meas.amp[1] <= 16'h01F4;
    wait_flag(0, 1'b1);
    chk_rng(n, 58, 76);
    ahb(1'b0, 8'h08, 32'h0);
    chk_val(rd, 32'h5);
    ahb(1'b1, 8'h00, 32'h11);
    meas.amp[1] <= 16'h0032;
    tick(20);
    chk_val({31'h0, flags.pickup}, 32'h1);
    // Source 3 follows only its own variable; source 2 blocks on its own
    ahb(1'b1, 8'h00, 32'h31);
    blk_var <= 3'h3;
    tick(8);
    chk_val({31'h0, flags.pickup}, 32'h1);
    blk_var <= 3'h4;
    wait_flag(0, 1'b0);
    chk_rng(n, 1, 8);
    ahb(1'b1, 8'h00, 32'h21);
    blk_var <= 3'h2;
    tick(80);
    chk_val({27'h0, flags}, 32'h0);
    blk_var <= 3'h0;
    wait_flag(0, 1'b1);
    chk_rng(n, 40, 54);
    // Global enable No, then an inactive group
    ahb(1'b1, 8'h00, 32'h10);
    wait_flag(0, 1'b0);
    chk_rng(n, 1, 6);
    tick(60);
    chk_val({27'h0, flags}, 32'h0);
    ahb(1'b1, 8'h00, 32'h111);
    tick(80);
    chk_val({27'h0, flags}, 32'h0);
    wrap_up();
  end
endmodule : tb_phase_undercurrent_protection

bind puc_top puc_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.clk(clk), .reset_n(reset_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .flags(flags));

`default_nettype wire
